// *** common/ppa_defs.svh ***
`ifndef PPA_DEFS_SVH
`define PPA_DEFS_SVH

`define PPA_NUM_PINS 12
`define PPA_SMALL_PINS 6
`define PPA_SEL_LSB 0
`define PPA_SEL_MSB 4
`define PPA_DIR_LSB 8
`define PPA_DIR_MSB 9
`define PPA_SEL_GPIO 5'h00
`define PPA_SEL_ANALOG 5'h1F
`define PPA_MODE_RESET 16'h0000

`define PPA_OFF_DATA 8'h00
`define PPA_OFF_SET 8'h04
`define PPA_OFF_CLR 8'h08
`define PPA_OFF_CTRL 8'h0C
`define PPA_OFF_MODE0 8'h40

`define PPA_CTRL_HWR_DIS 0
`define PPA_CTRL_DBG_LSB 1
`define PPA_CTRL_DBG_MSB 2
`define PPA_CTRL_WEAK 3
`define PPA_CTRL_SLEEP 4
`define PPA_CTRL_QDEC_OVR 5
`define PPA_CTRL_RESET 32'h00000000

`define PPA_PIN_HWR 0
`define PPA_PIN_SWCLK 2
`define PPA_PIN_SWDIO 5
`define PPA_PIN_SWDIO_ALT1 1
`define PPA_PIN_SWDIO_ALT2 10

`endif

// *** common/ppa_pkg.sv ***
package ppa_pkg;
  typedef enum logic [1:0] {
    PPA_DIR_IN = 2'b00,
    PPA_DIR_IN_PU = 2'b01,
    PPA_DIR_IN_PD = 2'b10,
    PPA_DIR_OUT = 2'b11
  } ppa_dir_type;

  typedef enum logic [1:0] {
    PPA_DBG_DEFAULT = 2'b00,
    PPA_DBG_ALT1 = 2'b01,
    PPA_DBG_ALT2 = 2'b10,
    PPA_DBG_OFF = 2'b11
  } ppa_dbg_type;

  typedef enum logic [1:0] {
    PPA_BUS_IDLE = 2'b00,
    PPA_BUS_DONE = 2'b01
  } ppa_bus_type;
endpackage

// *** design/ppa_input_router.sv ***
`timescale 1ns/1ps
`include "ppa_defs.svh"
module ppa_input_router #(
  parameter int NUM_PINS = `PPA_NUM_PINS,
  parameter int NUM_FUNCS = 32
) (
  input wire logic [5*NUM_PINS-1:0] pin_sel,
  input wire logic [NUM_PINS-1:0] pin_level,
  input wire logic [NUM_PINS-1:0] pin_is_input,
  output logic [NUM_FUNCS-1:0] periph_in
);
  // lowest-numbered pin wins: scan downward so the last write is the lowest
  always_comb begin
    periph_in = '0;
    for (int f = 1; f < NUM_FUNCS; f++) begin
      for (int p = NUM_PINS - 1; p >= 0; p--) begin
        if (pin_is_input[p] && pin_sel[5*p +: 5] == 5'(f)) begin
          periph_in[f] = pin_level[p];
        end
      end
    end
  end
endmodule

// *** design/ppa_gpio_port.sv ***
`timescale 1ns/1ps
`include "ppa_defs.svh"
// Function
// - twelve port bits 0..11; small package variant exposes only bits 0..5.
// - five-bit select field, mode bits 4..0, routes any peripheral signal to a pin.
// - several pins on one peripheral input: lowest numbered pin feeds it.
// - mode bits 9..8: input, input pull-up, input pull-down, output.
// - pulls forced off in output or analog mode.
// - select code zero connects the pin to the GPIO latch registers.
// - data input and output registers share one address.
// - data read returns live pin levels; analog pins read zero.
// - data write loads the output latch.
// - set register ones force latch bits high; zeros ignored.
// - clear register ones force latch bits low; zeros ignored.
// - debug data on bit 5, clock on bit 2; selectable alternates bits 1, 10.
// - bit 0 is hardware reset input unless disabled by control bit.
// - decoder channels on fixed default pins, overridden by channel select.
// - analog inputs fixed on bits 1, 2, 6, 7, chosen by select field.
// - on sleep, pad control and outputs are held until wake-up.
// - weak-drive control picks normal or reduced drive.
module ppa_gpio_port #(
  parameter int NUM_PINS = `PPA_NUM_PINS,
  parameter bit SMALL_PACKAGE = 1'b0,
  parameter int NUM_FUNCS = 32,
  parameter int QDEC_CH = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  output logic [NUM_PINS-1:0] pad_pull_up,
  output logic [NUM_PINS-1:0] pad_pull_down,
  output logic [NUM_PINS-1:0] pad_analog_en,
  output logic pad_weak_drive,
  input wire logic [NUM_FUNCS-1:0] periph_out,
  input wire logic [NUM_FUNCS-1:0] periph_oe,
  output logic [NUM_FUNCS-1:0] periph_in,
  output logic hw_reset_req,
  output logic debug_clk_in,
  output logic debug_data_in,
  input wire logic debug_data_out,
  input wire logic debug_data_oe,
  input wire logic [2*QDEC_CH*4-1:0] decoder_channel_pin_select,
  output logic [2*QDEC_CH-1:0] decoder_channel_in,
  output logic [3:0] analog_pin_active
);
  localparam logic [NUM_PINS-1:0] AVAIL_MASK =
    SMALL_PACKAGE ? NUM_PINS'((1 << `PPA_SMALL_PINS) - 1) : '1;
  // analog-capable pins: bits 1, 2, 6, 7
  localparam logic [NUM_PINS-1:0] ANALOG_PINS = NUM_PINS'(12'h0C6);
  // default decoder pins per channel A,B: ch1 1/2, ch2 3/4, ch3 5/6, ch4 7/11, ch5 9/10, ch6 0/8
  localparam logic [47:0] QDEC_DEFAULT = 48'h8_0_A_9_B_7_6_5_4_3_2_1;

  logic [15:0] mode_reg [NUM_PINS];
  logic [NUM_PINS-1:0] latch_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] readdata_reg;
  logic done_reg;
  logic [1:0] resp_reg;
  logic [NUM_PINS-1:0] hold_out_reg;
  logic [NUM_PINS-1:0] hold_oe_reg;
  logic [NUM_PINS-1:0] hold_pu_reg;
  logic [NUM_PINS-1:0] hold_pd_reg;
  logic [NUM_PINS-1:0] hold_an_reg;
  logic hold_weak_reg;

  logic req;
  logic mode_hit;
  logic [3:0] mode_idx;
  logic mapped;
  logic [NUM_PINS-1:0] wmask;
  logic [5*NUM_PINS-1:0] sel_flat;
  logic [NUM_PINS-1:0] is_analog;
  logic [NUM_PINS-1:0] is_output;
  logic [NUM_PINS-1:0] is_input;
  logic [NUM_PINS-1:0] live_out;
  logic [NUM_PINS-1:0] live_oe;
  logic [NUM_PINS-1:0] live_pu;
  logic [NUM_PINS-1:0] live_pd;
  logic [NUM_PINS-1:0] fixed_in_mask;
  logic [NUM_PINS-1:0] read_level;
  logic [3:0] dbg_data_pin;
  ppa_pkg::ppa_dbg_type dbg_sel;
  logic sleeping;

  function automatic logic [4:0] sel_of(input logic [15:0] m);
    sel_of = m[`PPA_SEL_MSB:`PPA_SEL_LSB];
  endfunction

  function automatic ppa_pkg::ppa_dir_type dir_of(input logic [15:0] m);
    dir_of = ppa_pkg::ppa_dir_type'(m[`PPA_DIR_MSB:`PPA_DIR_LSB]);
  endfunction

  assign req = avs_read | avs_write;
  assign mode_hit = (avs_address >= `PPA_OFF_MODE0) &&
                    (avs_address < `PPA_OFF_MODE0 + 8'(4 * NUM_PINS)) && (avs_address[1:0] == 2'b00);
  assign mode_idx = 4'((avs_address - `PPA_OFF_MODE0) >> 2);
  assign mapped = mode_hit || avs_address == `PPA_OFF_DATA || avs_address == `PPA_OFF_SET ||
                  avs_address == `PPA_OFF_CLR || avs_address == `PPA_OFF_CTRL;
  assign wmask = NUM_PINS'({avs_byteenable[1] ? 8'hFF : 8'h00, avs_byteenable[0] ? 8'hFF : 8'h00}) & AVAIL_MASK;
  assign sleeping = ctrl_reg[`PPA_CTRL_SLEEP];
  assign dbg_sel = ppa_pkg::ppa_dbg_type'(ctrl_reg[`PPA_CTRL_DBG_MSB:`PPA_CTRL_DBG_LSB]);

  // one wait cycle: request taken, answered with waitrequest low on next edge
  assign avs_waitrequest = req & ~done_reg;
  assign avs_readdata = readdata_reg;
  assign avs_response = resp_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= req & ~done_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_reg <= 2'b00;
    end else if (req & ~done_reg) begin
      resp_reg <= mapped ? 2'b00 : 2'b10;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_reg <= 32'h00000000;
    end else if (avs_read & ~done_reg) begin
      readdata_reg <= 32'h00000000;
      if (avs_address == `PPA_OFF_DATA) begin
        readdata_reg <= 32'(read_level);
      end else if (avs_address == `PPA_OFF_CTRL) begin
        readdata_reg <= ctrl_reg;
      end else if (mode_hit) begin
        readdata_reg <= 32'(mode_reg[mode_idx]);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        mode_reg[i] <= `PPA_MODE_RESET;
      end
    end else if (avs_write & done_reg & mode_hit & AVAIL_MASK[mode_idx]) begin
      if (avs_byteenable[0]) begin
        mode_reg[mode_idx][7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        mode_reg[mode_idx][15:8] <= avs_writedata[15:8];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_reg <= '0;
    end else if (avs_write & done_reg) begin
      case (avs_address)
        `PPA_OFF_DATA: latch_reg <= (latch_reg & ~wmask) | (avs_writedata[NUM_PINS-1:0] & wmask);
        `PPA_OFF_SET: latch_reg <= latch_reg | (avs_writedata[NUM_PINS-1:0] & wmask);
        `PPA_OFF_CLR: latch_reg <= latch_reg & ~(avs_writedata[NUM_PINS-1:0] & wmask);
        default: latch_reg <= latch_reg;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `PPA_CTRL_RESET;
    end else if (avs_write & done_reg & (avs_address == `PPA_OFF_CTRL) & avs_byteenable[0]) begin
      ctrl_reg <= {24'h000000, 2'b00, avs_writedata[5:0]};
    end
  end

  always_comb begin
    dbg_data_pin = 4'(`PPA_PIN_SWDIO);
    case (dbg_sel)
      ppa_pkg::PPA_DBG_ALT1: dbg_data_pin = 4'(`PPA_PIN_SWDIO_ALT1);
      ppa_pkg::PPA_DBG_ALT2: dbg_data_pin = 4'(`PPA_PIN_SWDIO_ALT2);
      default: dbg_data_pin = 4'(`PPA_PIN_SWDIO);
    endcase
  end

  always_comb begin
    fixed_in_mask = '0;
    if (!ctrl_reg[`PPA_CTRL_HWR_DIS]) begin
      fixed_in_mask[`PPA_PIN_HWR] = 1'b1;
    end
    if (dbg_sel != ppa_pkg::PPA_DBG_OFF) begin
      fixed_in_mask[`PPA_PIN_SWCLK] = 1'b1;
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      sel_flat[5*p +: 5] = sel_of(mode_reg[p]);
      is_analog[p] = ANALOG_PINS[p] && sel_of(mode_reg[p]) == `PPA_SEL_ANALOG;
      is_output[p] = dir_of(mode_reg[p]) == ppa_pkg::PPA_DIR_OUT;
      is_input[p] = AVAIL_MASK[p] && !is_analog[p] && !fixed_in_mask[p];
      live_pu[p] = AVAIL_MASK[p] && !is_analog[p] && dir_of(mode_reg[p]) == ppa_pkg::PPA_DIR_IN_PU;
      live_pd[p] = AVAIL_MASK[p] && !is_analog[p] && dir_of(mode_reg[p]) == ppa_pkg::PPA_DIR_IN_PD;
      live_out[p] = 1'b0;
      live_oe[p] = 1'b0;
      // duplicates of one peripheral output across pins are left to software
      if (AVAIL_MASK[p] && !is_analog[p] && !fixed_in_mask[p] && is_output[p]) begin
        if (sel_of(mode_reg[p]) == `PPA_SEL_GPIO) begin
          live_out[p] = latch_reg[p];
          live_oe[p] = 1'b1;
        end else begin
          live_out[p] = periph_out[sel_of(mode_reg[p])];
          live_oe[p] = periph_oe[sel_of(mode_reg[p])];
        end
      end
    end
    if (dbg_sel != ppa_pkg::PPA_DBG_OFF) begin
      live_out[dbg_data_pin] = debug_data_out;
      live_oe[dbg_data_pin] = debug_data_oe;
      live_pu[dbg_data_pin] = 1'b0;
      live_pd[dbg_data_pin] = 1'b0;
    end
    read_level = pad_in & AVAIL_MASK & ~is_analog;
  end

  ppa_input_router #(
    .NUM_PINS(NUM_PINS),
    .NUM_FUNCS(NUM_FUNCS)
  ) u_router (
    .pin_sel(sel_flat),
    .pin_level(pad_in),
    .pin_is_input(is_input),
    .periph_in(periph_in)
  );

  // pad state frozen while asleep so pins hold across the power-down
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_out_reg <= '0;
      hold_oe_reg <= '0;
      hold_pu_reg <= '0;
      hold_pd_reg <= '0;
      hold_an_reg <= '0;
      hold_weak_reg <= 1'b0;
    end else if (!sleeping) begin
      hold_out_reg <= live_out;
      hold_oe_reg <= live_oe;
      hold_pu_reg <= live_pu & ~live_oe;
      hold_pd_reg <= live_pd & ~live_oe;
      hold_an_reg <= is_analog;
      hold_weak_reg <= ctrl_reg[`PPA_CTRL_WEAK];
    end
  end

  assign pad_out = hold_out_reg;
  assign pad_oe = hold_oe_reg;
  assign pad_pull_up = hold_pu_reg;
  assign pad_pull_down = hold_pd_reg;
  assign pad_analog_en = hold_an_reg;
  assign pad_weak_drive = hold_weak_reg;
  assign analog_pin_active = {hold_an_reg[7], hold_an_reg[6], hold_an_reg[2], hold_an_reg[1]};

  assign hw_reset_req = !ctrl_reg[`PPA_CTRL_HWR_DIS] && pad_in[`PPA_PIN_HWR];
  assign debug_clk_in = (dbg_sel != ppa_pkg::PPA_DBG_OFF) && pad_in[`PPA_PIN_SWCLK];
  assign debug_data_in = (dbg_sel != ppa_pkg::PPA_DBG_OFF) && pad_in[dbg_data_pin];

  always_comb begin
    for (int c = 0; c < 2 * QDEC_CH; c++) begin
      if (ctrl_reg[`PPA_CTRL_QDEC_OVR]) begin
        decoder_channel_in[c] = pad_in[4'(decoder_channel_pin_select[4*c +: 4] % NUM_PINS)];
      end else begin
        decoder_channel_in[c] = pad_in[QDEC_DEFAULT[4*c +: 4]];
      end
    end
  end
endmodule

// *** bench/ppa_gpio_port_chk.sv ***
`timescale 1ns/1ps
module ppa_gpio_port_chk #(
  parameter int NUM_PINS = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic [NUM_PINS-1:0] pad_pull_up,
  input wire logic [NUM_PINS-1:0] pad_pull_down,
  input wire logic [NUM_PINS-1:0] pad_analog_en,
  input wire logic [3:0] analog_pin_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rd_done;
    avs_read && !avs_waitrequest;
  endsequence
  AST_ACK: assert property (req_wait |=> !avs_waitrequest)
    else $error("request not answered");
  AST_DIN: assert property (rd_done ##0 (avs_address == 8'h00) |->
    avs_response == 2'b00 && avs_readdata == 32'($past(pad_in) & ~$past(pad_analog_en)))
    else $error("port data read wrong");
  AST_UNM: assert property (rd_done ##0 (avs_address == 8'h30) |->
    avs_response == 2'b10 && avs_readdata == 32'h0) else $error("unmapped read wrong");
  AST_HOLD: assert property (!avs_read && !avs_write |->
    $stable(avs_readdata) && $stable(avs_response)) else $error("read data moved");
  AST_PULL_OFF: assert property (!(|((pad_oe | pad_analog_en) & (pad_pull_up | pad_pull_down))))
    else $error("pull left on");
  AST_PULL_EXCL: assert property (!(|(pad_pull_up & pad_pull_down)))
    else $error("both pulls on");
  AST_ANA_PINS: assert property ((32'(pad_analog_en) & 32'hFFFFFF39) == 32'h0)
    else $error("analog on wrong pin");
  AST_ANA_ACT: assert property (analog_pin_active ==
    {pad_analog_en[7], pad_analog_en[6], pad_analog_en[2], pad_analog_en[1]}) else $error("analog flags");
endmodule

// *** bench/ppa_pin_model.sv ***
`timescale 1ns/1ps
module ppa_pin_model #(
  parameter int N = 12
) (
  input wire logic clk,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pull_up,
  input wire logic [N-1:0] pad_pull_down,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  output logic [N-1:0] pad_in
);
  // floating pins wander so a stale level never passes
  logic flt = 1'b0;
  always_ff @(posedge clk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = flt;
    end
  end
endmodule

// *** bench/tb_port_pin_assignment_gpio.sv ***
`timescale 1ns/1ps
module tb_port_pin_assignment_gpio;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, pad_weak_drive, hw_reset_req, debug_clk_in, debug_data_in;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, periph_out, periph_oe, periph_in, rdat;
  logic [1:0] avs_response, rsp;
  logic [11:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, pad_analog_en, ext_en, ext_val, dec_in;
  logic [3:0] analog_pin_active;
  logic [47:0] dsel;
  logic dbo, dbe;
  logic [3:0] qp[12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'h9, 4'hA, 4'h0, 4'h8};
  int error_cnt, checked;
  int dp[3] = '{5, 1, 10};
  logic [7:0] oa[6] = '{8'h00, 8'h04, 8'h08, 8'h04, 8'h08, 8'h08};
  logic [11:0] od[6] = '{12'h008, 12'h010, 12'h008, 12'h000, 12'h000, 12'h018};
  logic [1:0] ox[6] = '{2'b01, 2'b11, 2'b10, 2'b10, 2'b10, 2'b00};
  ppa_gpio_port uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .pad_analog_en(pad_analog_en),
    .pad_weak_drive(pad_weak_drive), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .hw_reset_req(hw_reset_req), .debug_clk_in(debug_clk_in), .debug_data_in(debug_data_in),
    .debug_data_out(dbo), .debug_data_oe(dbe), .decoder_channel_pin_select(dsel),
    .decoder_channel_in(dec_in), .analog_pin_active(analog_pin_active));
  ppa_pin_model pins (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  task t(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task md(input int n, input logic [1:0] d, input logic [4:0] s);
    wr(8'h40 + 8'(4 * n), {22'h0, d, 3'h0, s});
  endtask
  task results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results;
  end
  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    periph_out = 32'h0;
    periph_oe = 32'h0;
    dbo = 1'b0;
    dbe = 1'b0;
    dsel = 48'h0;
    ext_en = 12'hFFF;
    ext_val = 12'hA5C;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00);
    t("din", 32'hA5C, rdat);
    t("dclk", 32'h1, debug_clk_in);
    t("hwr", 32'h0, hw_reset_req);
    for (int n = 0; n < 12; n++) begin
      rd(8'h40 + 8'(4 * n));
      t("mrst", 32'h0, rdat);
      md(n, 2'(n), 5'h1F - 5'(n));
      rd(8'h40 + 8'(4 * n));
      t("mode", {22'h0, 2'(n), 3'h0, 5'h1F - 5'(n)}, rdat);
      md(n, 2'b00, 5'h00);
    end
    ext_en <= 12'hEE7;
    for (int d = 0; d < 4; d++) begin
      md(3, 2'(d), 5'h00);
      repeat (2) @(posedge clk);
      t("pu", 32'(d == 1), pad_pull_up[3]);
      t("pd", 32'(d == 2), pad_pull_down[3]);
      t("oe", 32'(d == 3), pad_oe[3]);
    end
    md(4, 2'b11, 5'h00);
    for (int k = 0; k < 6; k++) begin
      wr(oa[k], {20'h0, od[k]});
      repeat (2) @(posedge clk);
      t("pout", 32'(ox[k]), pad_out[4:3]);
      rd(8'h00);
      t("plive", 32'(ox[k]), rdat[4:3]);
    end
    wr(8'h04, 32'h010);
    md(4, 2'b01, 5'h00);
    repeat (2) @(posedge clk);
    t("oe4", 32'h0, pad_oe[4]);
    md(8, 2'b11, 5'h03);
    periph_oe <= 32'h8;
    for (int v = 0; v < 2; v++) begin
      periph_out <= 32'(v) << 3;
      repeat (3) @(posedge clk);
      t("rout", 32'(v), pad_out[8]);
    end
    md(9, 2'b00, 5'h07);
    md(11, 2'b00, 5'h07);
    for (int v = 0; v < 2; v++) begin
      ext_val[9] <= v[0];
      ext_val[11] <= !v[0];
      repeat (3) @(posedge clk);
      t("rin", 32'(v), periph_in[7]);
    end
    ext_val[6] <= 1'b1;
    md(6, 2'b01, 5'h1F);
    repeat (2) @(posedge clk);
    t("ana", 32'h1, pad_analog_en[6]);
    t("apu", 32'h0, pad_pull_up[6]);
    t("aact", 32'h4, analog_pin_active);
    rd(8'h00);
    t("ard", 32'h0, rdat[6]);
    // weak drive first, so the hold captures it
    wr(8'h0C, 32'h08);
    wr(8'h0C, 32'h18);
    wr(8'h00, 32'h008);
    repeat (2) @(posedge clk);
    t("hold", 32'h0, pad_out[3]);
    t("weak", 32'h1, pad_weak_drive);
    wr(8'h0C, 32'h0);
    repeat (2) @(posedge clk);
    t("wake", 32'h1, pad_out[3]);
    t("norm", 32'h0, pad_weak_drive);
    ext_val[0] <= 1'b1;
    repeat (2) @(posedge clk);
    t("hwr", 32'h1, hw_reset_req);
    wr(8'h0C, 32'h1);
    t("hwd", 32'h0, hw_reset_req);
    for (int k = 0; k < 3; k++) begin
      ext_val <= 12'h001 << dp[k];
      wr(8'h0C, 32'(k) << 1);
      t("ddat", 32'h1, debug_data_in);
    end
    ext_val <= 12'h004;
    wr(8'h0C, 32'h06);
    t("doff", 32'h0, debug_clk_in);
    ext_val <= 12'h0A6;
    repeat (2) @(posedge clk);
    for (int c = 0; c < 12; c++) begin
      t("qdef", 32'(pad_in[qp[c]]), dec_in[c]);
    end
    dsel <= 48'h0123456789AB;
    wr(8'h0C, 32'h20);
    for (int c = 0; c < 12; c++) begin
      t("qsel", 32'(pad_in[11 - c]), dec_in[c]);
    end
    dbo <= 1'b1;
    dbe <= 1'b1;
    repeat (2) @(posedge clk);
    t("dout", 32'h1, pad_out[5]);
    t("doe", 32'h1, pad_oe[5]);
    dbe <= 1'b0;
    rd(8'h30);
    t("unm", 32'h0, rdat);
    t("rsp", 32'h2, rsp);
    results;
  end
endmodule
bind ppa_gpio_port ppa_gpio_port_chk #(.NUM_PINS(NUM_PINS)) u_chk (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .pad_in(pad_in), .pad_oe(pad_oe),
  .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .pad_analog_en(pad_analog_en),
  .analog_pin_active(analog_pin_active));
